// *** rtl/acf_top.sv ***
// How it works
// R1 - byte swap high puts low byte on upper lanes, high byte on lower lanes
// R2 - coding select high gives straight binary, low inverts the msb
// R3 - fast select and normal_n both high select wideband fast mode
// R4 - fast select high with normal_n low selects fast mode
// R5 - host keeps starting conversions often enough in either fast mode
// R6 - fast select and normal_n both low select normal mode
// R7 - serial select high uses serial port, leftover data pins float
// R8 - serial select low presents results on the parallel data pins
// R9 - data bits 0 and 1 are driven in every interface mode
// R10 - in parallel mode pins 2 and 3 carry word bits 2 and 3
// R11 - master read-after-convert reads divide pins and slows serial clock
// R12 - other serial modes float the divide pins and ignore them
// R13 - divide codes 0..3 give 8, 16, 32, 64 ns minimum clock period
// R14 - in fast mode host leaves at most 1 ms between starts
// R15 - clock source low makes device clock master, high makes it slave
// R16 - config applies to formatter and pin mux before next result
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module acf_top #(
	parameter int GAP_CYCLES = acf_pkg::START_GAP_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter core side
	input wire logic conv_start,
	input wire logic result_valid,
	input wire logic [15:0] result_data,
	output logic [1:0] conv_mode,
	// data pins
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic [15:0] data_oe,
	// serial pins
	output logic sclk_out,
	output logic sclk_oe,
	output logic sdout,
	output logic sdout_oe
);
	localparam int GAP_W = $clog2(GAP_CYCLES + 1);
	localparam int BIT_W = $clog2(acf_pkg::RESULT_BITS + 1);

	logic aw_held_q, aw_held_d;
	logic [3:0] awaddr_q, awaddr_d;
	logic w_held_q, w_held_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic [acf_pkg::CFG_W-1:0] cfg_q, cfg_d;
	logic late_q, late_d;
	logic do_write;
	logic late_clear;
	logic [15:0] fmt_word;
	logic [15:0] word_q, word_d;
	logic [15:0] pin_out_q, pin_out_d;
	logic [15:0] pin_oe_q, pin_oe_d;
	logic [1:0] div_meta_q, div_sync_q;
	logic [1:0] div_code;
	logic [GAP_W-1:0] gap_q, gap_d;
	acf_pkg::acf_shift_state_t sh_q, sh_d;
	logic [15:0] shift_q, shift_d;
	logic [BIT_W-1:0] bits_q, bits_d;
	logic sclk_q, sclk_d;
	logic tick;

	logic serial_on;
	logic master_mode;
	logic mrac_mode;
	acf_pkg::acf_conv_mode_t mode;
	logic [31:0] status_word;

	assign serial_on = cfg_q[acf_pkg::CFG_SERIAL_BIT];
	assign master_mode = serial_on && !cfg_q[acf_pkg::CFG_CLKSRC_BIT]; // [R15]
	assign mrac_mode = master_mode && !cfg_q[acf_pkg::CFG_RDC_BIT];
	assign div_code = mrac_mode ? div_sync_q : 2'b00; // [R11] [R12]

	always_comb begin
		if (!cfg_q[acf_pkg::CFG_FAST_BIT]) begin
			mode = acf_pkg::ACF_NORMAL; // [R6]
		end else if (cfg_q[acf_pkg::CFG_NORMAL_N_BIT]) begin
			mode = acf_pkg::ACF_WIDEBAND; // [R3]
		end else begin
			mode = acf_pkg::ACF_FAST; // [R4]
		end
	end
	assign conv_mode = mode;

	acf_formatter u_fmt (
		.raw(result_data),
		.coding_select(cfg_q[acf_pkg::CFG_CODING_BIT]),
		.byte_swap(cfg_q[acf_pkg::CFG_SWAP_BIT]),
		.word(fmt_word)
	);

	acf_sclk_div #(
		.CNT_W(4)
	) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(sh_q == acf_pkg::ACF_SH_RUN),
		.code(div_code),
		.tick(tick)
	);

	always_comb begin
		status_word = '0;
		status_word[acf_pkg::STAT_MODE_LSB +: 2] = mode;
		status_word[acf_pkg::STAT_SERIAL_BIT] = serial_on;
		status_word[acf_pkg::STAT_MRAC_BIT] = mrac_mode;
		status_word[acf_pkg::STAT_DIV_LSB +: 2] = div_code;
		status_word[acf_pkg::STAT_LATE_BIT] = late_q;
		status_word[acf_pkg::STAT_BUSY_BIT] = (sh_q == acf_pkg::ACF_SH_RUN);
	end

	// bus: address and data are held independently, answer follows both
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign late_clear = do_write && (awaddr_q == acf_pkg::STAT_OFS) && wstrb_q[0]
		&& wdata_q[acf_pkg::STAT_LATE_BIT];

	always_comb begin
		aw_held_d = aw_held_q;
		awaddr_d = awaddr_q;
		w_held_d = w_held_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q && !s_axi_bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !s_axi_rready;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		cfg_d = cfg_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_d = 1'b1;
			awaddr_d = {s_axi_awaddr[3:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (do_write) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = acf_pkg::AXI_OKAY;
			unique case (awaddr_q)
				acf_pkg::CFG_OFS: begin
					if (wstrb_q[0]) begin
						cfg_d = wdata_q[acf_pkg::CFG_W-1:0]; // [R16]
					end
				end
				acf_pkg::STAT_OFS: bresp_d = acf_pkg::AXI_OKAY;
				default: bresp_d = acf_pkg::AXI_SLVERR;
			endcase
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = acf_pkg::AXI_OKAY;
			unique case ({s_axi_araddr[3:2], 2'b00})
				acf_pkg::CFG_OFS: rdata_d = {25'h0, cfg_q};
				acf_pkg::STAT_OFS: rdata_d = status_word;
				acf_pkg::RES_OFS: rdata_d = {16'h0, word_q};
				default: begin
					rdata_d = 32'h0;
					rresp_d = acf_pkg::AXI_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q <= 4'h0;
			w_held_q <= 1'b0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= 2'h0;
			cfg_q <= acf_pkg::CFG_RST;
		end else begin
			aw_held_q <= aw_held_d;
			awaddr_q <= awaddr_d;
			w_held_q <= w_held_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			cfg_q <= cfg_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// start spacing watch: the host owns the spacing, we only flag a late start
	always_comb begin
		late_d = late_q && !late_clear;
		gap_d = gap_q;
		if (conv_start || mode == acf_pkg::ACF_NORMAL) begin
			gap_d = '0;
		end else if (gap_q != GAP_W'(GAP_CYCLES)) begin
			gap_d = gap_q + GAP_W'(1);
		end
		// a late start in the clearing cycle still sets the flag
		if (conv_start && mode != acf_pkg::ACF_NORMAL && gap_q == GAP_W'(GAP_CYCLES)) begin
			late_d = 1'b1; // [R5] [R14]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			late_q <= 1'b0;
			gap_q <= '0;
		end else begin
			late_q <= late_d;
			gap_q <= gap_d;
		end
	end

	// result word and pin mux, registered so the pins come from flops
	always_comb begin
		word_d = result_valid ? fmt_word : word_q; // [R16]
		pin_out_d = word_q;
		pin_oe_d = 16'hffff; // [R8] [R10]
		if (serial_on) begin
			pin_out_d = {14'h0, word_q[1:0]};
			pin_oe_d = 16'h0003; // [R7] [R9] [R12]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word_q <= 16'h0;
			pin_out_q <= 16'h0;
			pin_oe_q <= 16'h0003;
			div_meta_q <= 2'h0;
			div_sync_q <= 2'h0;
		end else begin
			word_q <= word_d;
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
			div_meta_q <= data_in[3:2];
			div_sync_q <= div_meta_q; // [R11]
		end
	end

	assign data_out = pin_out_q;
	assign data_oe = pin_oe_q;

	// master serial shifter: msb first, data changes on the falling edge
	always_comb begin
		sh_d = sh_q;
		shift_d = shift_q;
		bits_d = bits_q;
		sclk_d = sclk_q;
		unique case (sh_q)
			acf_pkg::ACF_SH_IDLE: begin
				sclk_d = 1'b0;
				if (result_valid && master_mode) begin
					shift_d = fmt_word;
					bits_d = BIT_W'(acf_pkg::RESULT_BITS);
					sh_d = acf_pkg::ACF_SH_RUN;
				end
			end
			acf_pkg::ACF_SH_RUN: begin
				if (tick) begin
					sclk_d = ~sclk_q; // [R11] [R13]
					if (sclk_q) begin
						shift_d = {shift_q[14:0], 1'b0};
						bits_d = bits_q - BIT_W'(1);
						if (bits_q == BIT_W'(1)) begin
							sh_d = acf_pkg::ACF_SH_IDLE;
						end
					end
				end
				if (!master_mode) begin
					sh_d = acf_pkg::ACF_SH_IDLE;
					sclk_d = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh_q <= acf_pkg::ACF_SH_IDLE;
			shift_q <= 16'h0;
			bits_q <= '0;
			sclk_q <= 1'b0;
		end else begin
			sh_q <= sh_d;
			shift_q <= shift_d;
			bits_q <= bits_d;
			sclk_q <= sclk_d;
		end
	end

	assign sclk_out = sclk_q;
	assign sclk_oe = master_mode; // [R15]
	assign sdout = shift_q[15];
	assign sdout_oe = serial_on;
endmodule // acf_top
`default_nettype wire

// *** rtl/acf_pkg.sv ***
package acf_pkg;
	// register byte offsets on the control bus
	localparam logic [3:0] CFG_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam logic [3:0] RES_OFS = 4'h8;

	// config register fields
	localparam int CFG_SWAP_BIT = 0;
	localparam int CFG_CODING_BIT = 1;
	localparam int CFG_FAST_BIT = 2;
	localparam int CFG_NORMAL_N_BIT = 3;
	localparam int CFG_SERIAL_BIT = 4;
	localparam int CFG_CLKSRC_BIT = 5;
	localparam int CFG_RDC_BIT = 6;
	localparam int CFG_W = 7;
	localparam logic [6:0] CFG_RST = 7'h00;

	// status register fields
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_SERIAL_BIT = 2;
	localparam int STAT_MRAC_BIT = 3;
	localparam int STAT_DIV_LSB = 4;
	localparam int STAT_LATE_BIT = 6;
	localparam int STAT_BUSY_BIT = 7;

	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// timing
	localparam int CLK_NS = 8;
	localparam int SCLK_MIN_NS_0 = 8;
	localparam int SCLK_MIN_NS_1 = 16;
	localparam int SCLK_MIN_NS_2 = 32;
	localparam int SCLK_MIN_NS_3 = 64;
	// half period in cycles, whole period rounded up, never below one cycle
	localparam int SCLK_HALF_0 = ((SCLK_MIN_NS_0 + CLK_NS - 1) / CLK_NS + 1) / 2;
	localparam int SCLK_HALF_1 = ((SCLK_MIN_NS_1 + CLK_NS - 1) / CLK_NS + 1) / 2;
	localparam int SCLK_HALF_2 = ((SCLK_MIN_NS_2 + CLK_NS - 1) / CLK_NS + 1) / 2;
	localparam int SCLK_HALF_3 = ((SCLK_MIN_NS_3 + CLK_NS - 1) / CLK_NS + 1) / 2;
	localparam int START_GAP_US = 1000;
	localparam int START_GAP_CYCLES = START_GAP_US * 1000 / CLK_NS;
	localparam int RESULT_BITS = 16;

	typedef enum logic [1:0] {
		ACF_NORMAL = 2'b00,
		ACF_FAST = 2'b01,
		ACF_WIDEBAND = 2'b10
	} acf_conv_mode_t;

	typedef enum logic {
		ACF_SH_IDLE = 1'b0,
		ACF_SH_RUN = 1'b1
	} acf_shift_state_t;
endpackage

// *** rtl/acf_formatter.sv ***
`timescale 1ns/100ps
`default_nettype none
module acf_formatter (
	input wire logic [15:0] raw,
	input wire logic coding_select,
	input wire logic byte_swap,
	output logic [15:0] word
);
	logic [15:0] coded;

	always_comb begin
		coded = raw;
		if (!coding_select) begin
			coded[15] = ~raw[15]; // [R2]
		end
		word = byte_swap ? {coded[7:0], coded[15:8]} : coded; // [R1]
	end
endmodule // acf_formatter
`default_nettype wire

// *** rtl/acf_sclk_div.sv ***
`timescale 1ns/100ps
`default_nettype none
module acf_sclk_div #(
	parameter int CNT_W = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic [1:0] code,
	output logic tick
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] last;

	always_comb begin
		unique case (code) // [R13]
			2'b00: last = CNT_W'(acf_pkg::SCLK_HALF_0 - 1);
			2'b01: last = CNT_W'(acf_pkg::SCLK_HALF_1 - 1);
			2'b10: last = CNT_W'(acf_pkg::SCLK_HALF_2 - 1);
			2'b11: last = CNT_W'(acf_pkg::SCLK_HALF_3 - 1);
		endcase
		tick = run && (cnt_q >= last);
		if (!run || tick) begin
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // acf_sclk_div
`default_nettype wire

// *** test/acf_top_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module acf_top_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic result_valid,
	input wire logic [1:0] conv_mode,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe,
	input wire logic sclk_oe,
	input wire logic sdout_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	low_bits_a: assert property (data_oe[1:0] == 2'b11)
		else $error("data bits 0 or 1 released");
	mode_code_a: assert property (conv_mode != 2'b11)
		else $error("illegal conversion mode code");
	pin_dir_a: assert property (data_oe == 16'hffff || data_oe == 16'h0003)
		else $error("data pin enables out of shape");
	ser_pins_a: assert property (sclk_oe && $past(sclk_oe) |-> data_oe == 16'h0003)
		else $error("master serial with upper pins driven");
	sdout_en_a: assert property (sclk_oe |-> sdout_oe)
		else $error("serial clock driven without serial data");
	out_hold_a: assert property ($past(sdout_oe) == $past(sdout_oe, 2)
		&& !$past(result_valid, 2) |-> $stable(data_out))
		else $error("data pins moved without a result");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	b_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	r_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
endmodule // acf_top_sva
bind acf_top acf_top_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .result_valid, .conv_mode, .data_out, .data_oe,
	.sclk_oe, .sdout_oe);
`default_nettype wire

// *** test/acf_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module acf_host_model (
	input wire logic aclk,
	input wire logic clr,
	input wire logic [1:0] div_code,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe,
	input wire logic sclk_out,
	input wire logic sdout,
	output logic [15:0] data_in,
	output logic [15:0] ser_word,
	output logic [4:0] ser_bits,
	output logic [7:0] ser_period
);
	logic [15:0] float_q = 16'h5a5a;
	logic sclk_q = 1'b0;
	logic [7:0] cnt_q = 8'h00;
	// released pins toggle, except pins 2 and 3 which carry the divide code, so a stale level never passes for a driven one
	always_comb begin
		data_in = (data_oe & data_out) | (~data_oe & float_q);
		if (!data_oe[2]) data_in[2] = div_code[0];
		if (!data_oe[3]) data_in[3] = div_code[1];
	end
	// sampled on the rising serial clock, msb first
	always_ff @(posedge aclk) begin
		float_q <= ~float_q;
		sclk_q <= sclk_out;
		cnt_q <= cnt_q + 8'h01;
		if (clr) ser_bits <= 5'h00;
		else if (sclk_out && !sclk_q) begin
			ser_word <= {ser_word[14:0], sdout};
			ser_bits <= ser_bits + 5'h01;
			ser_period <= cnt_q;
			cnt_q <= 8'h01;
		end
	end
endmodule // acf_host_model
`default_nettype wire

// *** test/acf_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module acf_top_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awa = 4'h0;
	logic [3:0] ara = 4'h0;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic cs = 1'b0, rsv = 1'b0;
	logic [15:0] rsd = 16'h0;
	logic [1:0] div = 2'h3;
	logic awr, wrd, bv, arr, rv, sck, sck_oe, sdo, sdo_oe;
	logic [1:0] brs, rrs, cmode, rsp;
	logic [31:0] rdat, rdv;
	logic [15:0] din, dout, doe, sw;
	logic [4:0] sbits;
	logic [7:0] sper;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #4 aclk = ~aclk;
	acf_top #(.GAP_CYCLES(20)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(brs), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.conv_start(cs), .result_valid(rsv), .result_data(rsd), .conv_mode(cmode),
		.data_in(din), .data_out(dout), .data_oe(doe), .sclk_out(sck), .sclk_oe(sck_oe),
		.sdout(sdo), .sdout_oe(sdo_oe));
	acf_host_model host (.aclk(aclk), .clr(rsv), .div_code(div), .data_out(dout),
		.data_oe(doe), .sclk_out(sck), .sdout(sdo), .data_in(din), .ser_word(sw),
		.ser_bits(sbits), .ser_period(sper));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic h1, h2, p;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		// readies are combinational: judge the handshake at the negedge before the edge
		do begin
			@(negedge aclk);
			h1 = awv && awr;
			h2 = wv && wrd;
			@(posedge aclk);
			if (h1) awv <= 1'b0;
			if (h2) wv <= 1'b0;
			p = (awv && !h1) || (wv && !h2);
		end while (p);
		do begin
			@(negedge aclk);
			h1 = bv;
			rsp = brs;
			@(posedge aclk);
		end while (!h1);
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		logic h;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(negedge aclk);
			h = arr;
			@(posedge aclk);
		end while (!h);
		arv <= 1'b0;
		do begin
			@(negedge aclk);
			h = rv;
			rdv = rdat;
			rsp = rrs;
			@(posedge aclk);
		end while (!h);
		rry <= 1'b0;
	endtask
	task automatic push(input logic [15:0] v);
		@(posedge aclk);
		cs <= 1'b1; // one start per result; the caller sets the spacing, t_late lets the gap run out first
		rsv <= 1'b1;
		rsd <= v;
		@(posedge aclk);
		cs <= 1'b0;
		rsv <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
	task automatic t_reset;
		rd(acf_pkg::CFG_OFS);
		chk(rdv, 32'h0);
		chk(doe, 16'hffff);
		chk(sdo_oe, 1'b0);
		chk(cmode, 2'h0);
		$display("reset test done");
	endtask
	task automatic t_modes;
		logic [6:0] cf [4] = '{7'h0c, 7'h04, 7'h00, 7'h08};
		logic [1:0] ex [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
		for (int i = 0; i < 4; i++) begin
			wr(acf_pkg::CFG_OFS, {25'h0, cf[i]});
			chk(cmode, ex[i]);
		end
		$display("mode test done");
	endtask
	task automatic t_format;
		logic [15:0] w, e;
		for (int i = 0; i < 4; i++) begin
			wr(acf_pkg::CFG_OFS, i);
			push(16'h8c5a);
			w = i[1] ? 16'h8c5a : 16'h0c5a;
			e = i[0] ? {w[7:0], w[15:8]} : w;
			chk(dout, e);
			rd(acf_pkg::RES_OFS);
			chk(rdv, {16'h0, e});
		end
		wr(acf_pkg::RES_OFS, 32'h0);
		chk(rsp, acf_pkg::AXI_SLVERR);
		rd(4'hc);
		chk(rsp, acf_pkg::AXI_SLVERR);
		$display("format test done");
	endtask
	task automatic t_serial;
		// serial clock period in cycles for divide codes 0..2; code 0 rounds up to two
		int pc [3] = '{2, 2, 4};
		wr(acf_pkg::CFG_OFS, 32'h10);
		repeat (4) @(posedge aclk);
		chk(doe, 16'h0003);
		chk(sck_oe, 1'b1);
		chk(sdo_oe, 1'b1);
		rd(acf_pkg::STAT_OFS);
		chk(rdv[5:2], 4'hf);
		push(16'h1234);
		while (sbits != 5'h10) @(posedge aclk);
		chk(sw, 16'h9234);
		chk(sper, 64 / acf_pkg::CLK_NS);
		for (int c = 0; c < 3; c++) begin
			div <= c[1:0];
			repeat (4) @(posedge aclk);
			push(16'h00ff);
			while (sbits != 5'h10) @(posedge aclk);
			chk(sw, 16'h80ff);
			chk(sper, pc[c]);
		end
		wr(acf_pkg::CFG_OFS, 32'h50);
		repeat (4) @(posedge aclk);
		rd(acf_pkg::STAT_OFS);
		chk(rdv[5:2], 4'h1);
		chk(doe, 16'h0003);
		wr(acf_pkg::CFG_OFS, 32'h30);
		chk(sck_oe, 1'b0);
		$display("serial test done");
	endtask
	task automatic t_late;
		wr(acf_pkg::CFG_OFS, 32'h04);
		// let the start gap run out before the next start
		repeat (25) @(posedge aclk);
		push(16'h0001);
		rd(acf_pkg::STAT_OFS);
		chk(rdv, 32'h41);
		wr(acf_pkg::STAT_OFS, 32'h40);
		chk(rsp, acf_pkg::AXI_OKAY);
		push(16'h0002);
		rd(acf_pkg::STAT_OFS);
		chk(rdv, 32'h01);
		$display("late start test done");
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			$display("[FAIL] %0t run hung", $time);
			give_verdict;
		end
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_modes;
		t_format;
		t_serial;
		t_late;
		give_verdict;
	end
endmodule // acf_top_tb
`default_nettype wire
